// >>> umcs_top.v
// Mode selection, register access and baud clock generation of the UART.
// Operation
// - Reset clears FIFO enable: byte mode.
// - FIFO enable low ignores all other mode bits.
// - FIFO enable alone gives 16-entry FIFOs.
// - Size bit without enhanced mode gives 128.
// - Size bit writable only with divisor access set.
// - Size-bit features only while enhanced mode off.
// - Enhanced mode with FIFO enable gives 128.
// - Deep-buffer select pin is tied low.
// - Trigger enable uses programmable thresholds instead.
// - Prescaler divides by M plus N/8.
// - Prescaler divides by four after reset.
// - External clocks from ring, terminal, data-set pins.
// - Sample count resets zero; 0-3 mean 16.
// - Sample count 4-15 sets sample ticks per bit.
// - Fill levels and flow status are readable.
// - Writing 0xBF opens enhanced set, keeps format.
// - Additional control bit 6 exposes indexed set to reads; indexed writes pass whenever the enhanced set is closed.
`include "umcs_regs.vh"
`default_nettype none
module umcs_top #(
   parameter DATA_W = 8
)(
   input wire clock_i,
   input wire rst_n_i,
   input wire [2:0] addr_i,
   input wire wr_stb_i,
   input wire rd_stb_i,
   input wire [7:0] wdata_i,
   output wire [7:0] rdata_o,
   input wire [7:0] rx_data_i,
   input wire [7:0] rx_fill_level_i,
   input wire [7:0] tx_fill_level_i,
   input wire [7:0] flow_status_i,
   output wire tx_wr_ready_o,
   output wire tx_valid_o,
   input wire tx_ready_i,
   output wire [DATA_W-1:0] tx_data_o,
   input wire ring_indicate_pin_i,
   input wire terminal_ready_pin_i,
   input wire data_set_ready_pin_i,
   output wire [7:0] fifo_depth_o,
   output wire legacy_ext_en_o,
   output wire prog_trig_o,
   output wire [7:0] rx_trigger_o,
   output wire [7:0] tx_trigger_o,
   output wire [7:0] flow_low_o,
   output wire [7:0] flow_high_o,
   output wire sample_tick_o,
   output wire tx_bit_tick_o,
   output wire rx_bit_tick_o
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   reg [1:0] rst_sync_ff;
   wire rst_n;

   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_sync_ff <= 2'b00;
      end
      else
      begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   localparam DEEP_SEL_PIN = 1'b0;
   reg [7:0] fifo_control_ff;
   reg [7:0] line_format_control_ff;
   reg enh_open_ff;
   reg [7:0] enhanced_features_ff;
   reg [7:0] scratch_ff;
   reg [7:0] additional_control_ff;
   reg [7:0] clock_prescale_ratio_ff;
   reg [7:0] external_clock_select_ff;
   reg [7:0] sample_clock_count_ff;
   reg [7:0] rx_trigger_level_ff;
   reg [7:0] tx_trigger_level_ff;
   reg [7:0] flow_low_threshold_ff;
   reg [7:0] flow_high_threshold_ff;
   reg [7:0] rdata_ff;
   reg [7:0] nxt_rdata;
   wire div_access;
   wire wr_fifo;
   wire wr_efr;
   wire wr_index;
   wire buf_in_ready;

   assign div_access = line_format_control_ff[`UMCS_LCR_DIV_ACCESS];
   assign wr_efr = wr_stb_i & enh_open_ff & (addr_i == `UMCS_OFS_FIFO_CTRL);
   assign wr_fifo = wr_stb_i & ~enh_open_ff & (addr_i == `UMCS_OFS_FIFO_CTRL);
   assign wr_index = wr_stb_i & ~enh_open_ff & (addr_i == `UMCS_OFS_INDEX_DATA);

   always @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fifo_control_ff <= 8'h00;
         line_format_control_ff <= 8'h00;
         enh_open_ff <= 1'b0;
         enhanced_features_ff <= 8'h00;
         scratch_ff <= 8'h00;
      end
      else
      begin
         if (wr_stb_i & (addr_i == `UMCS_OFS_LINE_FMT))
         begin
            if (wdata_i == `UMCS_LCR_ENH_KEY)
            begin
               line_format_control_ff[`UMCS_LCR_DIV_ACCESS] <= 1'b1;
               enh_open_ff <= 1'b1;
            end
            else
            begin
               line_format_control_ff <= wdata_i;
               enh_open_ff <= 1'b0;
            end
         end
         if (wr_efr)
         begin
            enhanced_features_ff <= wdata_i;
         end
         if (wr_fifo)
         begin
            fifo_control_ff[4:0] <= wdata_i[4:0];
            fifo_control_ff[7:6] <= wdata_i[7:6];
            if (div_access)
            begin
               fifo_control_ff[`UMCS_FCR_SIZE] <= wdata_i[`UMCS_FCR_SIZE];
            end
         end
         if (wr_stb_i & (addr_i == `UMCS_OFS_SCRATCH))
         begin
            scratch_ff <= wdata_i;
         end
      end
   end

   // Indexed set: scratch selects the entry, the data offset carries it.
   always @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         additional_control_ff <= 8'h00;
         clock_prescale_ratio_ff <= `UMCS_RST_PRESCALE;
         external_clock_select_ff <= 8'h00;
         sample_clock_count_ff <= `UMCS_RST_SAMPLE_CNT;
         rx_trigger_level_ff <= 8'h00;
         tx_trigger_level_ff <= 8'h00;
         flow_low_threshold_ff <= 8'h00;
         flow_high_threshold_ff <= 8'h00;
      end
      else if (wr_index)
      begin
         if (scratch_ff == `UMCS_IDX_ADD_CTRL)
         begin
            additional_control_ff <= wdata_i;
         end
         else if (scratch_ff == `UMCS_IDX_PRESCALE)
         begin
            clock_prescale_ratio_ff <= wdata_i;
         end
         else if (scratch_ff == `UMCS_IDX_EXT_CLK)
         begin
            external_clock_select_ff <= wdata_i;
         end
         else if (scratch_ff == `UMCS_IDX_SAMPLE_CNT)
         begin
            sample_clock_count_ff <= wdata_i;
         end
         else if (scratch_ff == `UMCS_IDX_RX_TRIG)
         begin
            rx_trigger_level_ff <= wdata_i;
         end
         else if (scratch_ff == `UMCS_IDX_TX_TRIG)
         begin
            tx_trigger_level_ff <= wdata_i;
         end
         else if (scratch_ff == `UMCS_IDX_FLOW_LOW)
         begin
            flow_low_threshold_ff <= wdata_i;
         end
         else if (scratch_ff == `UMCS_IDX_FLOW_HIGH)
         begin
            flow_high_threshold_ff <= wdata_i;
         end
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   function [7:0] index_read;
      input [7:0] idx;
      begin
         if (idx == `UMCS_IDX_ADD_CTRL)
            index_read = additional_control_ff;
         else if (idx == `UMCS_IDX_PRESCALE)
            index_read = clock_prescale_ratio_ff;
         else if (idx == `UMCS_IDX_EXT_CLK)
            index_read = external_clock_select_ff;
         else if (idx == `UMCS_IDX_SAMPLE_CNT)
            index_read = sample_clock_count_ff;
         else if (idx == `UMCS_IDX_ADD_STATUS)
            index_read = flow_status_i;
         else if (idx == `UMCS_IDX_RX_FILL)
            index_read = rx_fill_level_i;
         else if (idx == `UMCS_IDX_TX_FILL)
            index_read = tx_fill_level_i;
         else if (idx == `UMCS_IDX_RX_TRIG)
            index_read = rx_trigger_level_ff;
         else if (idx == `UMCS_IDX_TX_TRIG)
            index_read = tx_trigger_level_ff;
         else if (idx == `UMCS_IDX_FLOW_LOW)
            index_read = flow_low_threshold_ff;
         else if (idx == `UMCS_IDX_FLOW_HIGH)
            index_read = flow_high_threshold_ff;
         else
            index_read = 8'h00;
      end
   endfunction

   always @*
   begin
      nxt_rdata = rdata_ff;
      if (rd_stb_i)
      begin
         if (addr_i == `UMCS_OFS_DATA)
            nxt_rdata = rx_data_i;
         else if (addr_i == `UMCS_OFS_FIFO_CTRL)
            nxt_rdata = enh_open_ff ? enhanced_features_ff :
                        {{2{fifo_control_ff[`UMCS_FCR_ENABLE]}}, 6'h01};
         else if (addr_i == `UMCS_OFS_LINE_FMT)
            nxt_rdata = line_format_control_ff;
         else if (addr_i == `UMCS_OFS_INDEX_DATA)
            nxt_rdata = additional_control_ff[`UMCS_ACR_INDEX_EN] ?
                        index_read(scratch_ff) : {2'b00, buf_in_ready, 5'h00};
         else if (addr_i == `UMCS_OFS_SCRATCH)
            nxt_rdata = scratch_ff;
         else
            nxt_rdata = 8'h00;
      end
   end

   always @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
         rdata_ff <= 8'h00;
      else
         rdata_ff <= nxt_rdata;
   end
   assign rdata_o = rdata_ff;

   // ----------------------------------------
   // Mode selection
   // ----------------------------------------
   wire fifo_en;
   wire enhanced;
   wire size_bit;
   reg [7:0] depth;

   assign fifo_en = fifo_control_ff[`UMCS_FCR_ENABLE];
   assign enhanced = enhanced_features_ff[`UMCS_EFR_ENHANCED];
   assign size_bit = fifo_control_ff[`UMCS_FCR_SIZE];

   always @*
   begin
      if (!fifo_en)
         depth = `UMCS_DEPTH_BYTE;
      else if (enhanced)
         depth = `UMCS_DEPTH_DEEP;
      else if (size_bit | DEEP_SEL_PIN)
         depth = `UMCS_DEPTH_DEEP;
      else
         depth = `UMCS_DEPTH_STD;
   end
   assign fifo_depth_o = depth;
   assign legacy_ext_en_o = fifo_en & ~enhanced & size_bit;

   // Programmable thresholds replace the legacy trigger bits.
   assign prog_trig_o = fifo_en & additional_control_ff[`UMCS_ACR_TRIG_EN];
   assign rx_trigger_o = prog_trig_o ? rx_trigger_level_ff :
                         {6'h00, fifo_control_ff[7:6]};
   assign tx_trigger_o = prog_trig_o ? tx_trigger_level_ff :
                         {6'h00, fifo_control_ff[5:4]};
   assign flow_low_o = flow_low_threshold_ff;
   assign flow_high_o = flow_high_threshold_ff;

   // ----------------------------------------
   // Transmit buffer
   // ----------------------------------------
   wire tx_push;
   assign tx_push = wr_stb_i & (addr_i == `UMCS_OFS_DATA) & ~div_access;
   assign tx_wr_ready_o = buf_in_ready;

   umcs_buffer #(.WIDTH(DATA_W), .AW(1)) u_txbuf (
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .in_valid_i(tx_push),
      .in_ready_o(buf_in_ready),
      .in_data_i(wdata_i[DATA_W-1:0]),
      .out_valid_o(tx_valid_o),
      .out_ready_i(tx_ready_i),
      .out_data_o(tx_data_o)
   );

   // ----------------------------------------
   // Prescaler and sample counter
   // ----------------------------------------
   // Eighths accumulate so a fractional ratio averages out exactly.
   reg [8:0] acc_ff;
   reg [4:0] tx_cnt_ff;
   reg [4:0] rx_cnt_ff;
   wire [8:0] ratio;
   wire [8:0] acc_sum;
   wire pre_tick;
   wire [4:0] samples;

   assign ratio = (clock_prescale_ratio_ff < 8'h08) ? `UMCS_EIGHTHS_ONE :
                  {1'b0, clock_prescale_ratio_ff};
   assign acc_sum = acc_ff + `UMCS_EIGHTHS_ONE;
   assign pre_tick = (acc_sum >= ratio);
   assign samples = (sample_clock_count_ff < `UMCS_SAMPLES_MIN) ? `UMCS_SAMPLES_DEFAULT :
                    {1'b0, sample_clock_count_ff[3:0]};

   always @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_ff <= 9'h000;
         tx_cnt_ff <= 5'h00;
         rx_cnt_ff <= 5'h00;
      end
      else
      begin
         acc_ff <= pre_tick ? (acc_sum - ratio) : acc_sum;
         if (pre_tick)
         begin
            tx_cnt_ff <= (tx_cnt_ff + 5'h01 >= samples) ? 5'h00 : tx_cnt_ff + 5'h01;
            rx_cnt_ff <= (rx_cnt_ff + 5'h01 >= samples) ? 5'h00 : rx_cnt_ff + 5'h01;
         end
      end
   end

   // ----------------------------------------
   // External clock pins
   // ----------------------------------------
   reg [2:0] ri_sync_ff;
   reg [2:0] dtr_sync_ff;
   reg [2:0] dsr_sync_ff;
   wire tx_ext_edge;
   wire rx_ext_edge;

   always @(posedge clock_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ri_sync_ff <= 3'h0;
         dtr_sync_ff <= 3'h0;
         dsr_sync_ff <= 3'h0;
      end
      else
      begin
         ri_sync_ff <= {ri_sync_ff[1:0], ring_indicate_pin_i};
         dtr_sync_ff <= {dtr_sync_ff[1:0], terminal_ready_pin_i};
         dsr_sync_ff <= {dsr_sync_ff[1:0], data_set_ready_pin_i};
      end
   end

   // Only the second and third stages feed the edge detectors.
   assign tx_ext_edge = external_clock_select_ff[`UMCS_CKS_TX_FROM_DTR] ?
                        (dtr_sync_ff[1] & ~dtr_sync_ff[2]) :
                        (ri_sync_ff[1] & ~ri_sync_ff[2]);
   assign rx_ext_edge = dsr_sync_ff[1] & ~dsr_sync_ff[2];

   assign sample_tick_o = pre_tick;
   assign tx_bit_tick_o = external_clock_select_ff[`UMCS_CKS_TX_EXT] ? tx_ext_edge :
                          (pre_tick & (tx_cnt_ff == 5'h00));
   assign rx_bit_tick_o = external_clock_select_ff[`UMCS_CKS_RX_EXT] ? rx_ext_edge :
                          (pre_tick & (rx_cnt_ff == 5'h00));
endmodule
`default_nettype wire

// >>> umcs_regs.vh
// Register offsets, field positions, reset values and timing counts of the mode and clock block.
`ifndef UMCS_REGS_VH
`define UMCS_REGS_VH
// ----------------------------------------
// Bus offsets in the eight-byte block
// ----------------------------------------
`define UMCS_OFS_DATA 3'h0
`define UMCS_OFS_FIFO_CTRL 3'h2
`define UMCS_OFS_LINE_FMT 3'h3
`define UMCS_OFS_INDEX_DATA 3'h5
`define UMCS_OFS_SCRATCH 3'h7
// ----------------------------------------
// Indexed control set
// ----------------------------------------
`define UMCS_IDX_ADD_CTRL 8'h00
`define UMCS_IDX_PRESCALE 8'h01
`define UMCS_IDX_EXT_CLK 8'h02
`define UMCS_IDX_SAMPLE_CNT 8'h03
`define UMCS_IDX_ADD_STATUS 8'h04
`define UMCS_IDX_RX_FILL 8'h05
`define UMCS_IDX_TX_FILL 8'h06
`define UMCS_IDX_RX_TRIG 8'h07
`define UMCS_IDX_TX_TRIG 8'h08
`define UMCS_IDX_FLOW_LOW 8'h09
`define UMCS_IDX_FLOW_HIGH 8'h0A
// ----------------------------------------
// Field positions
// ----------------------------------------
`define UMCS_FCR_ENABLE 0
`define UMCS_FCR_SIZE 5
`define UMCS_EFR_ENHANCED 4
`define UMCS_LCR_DIV_ACCESS 7
`define UMCS_ACR_TRIG_EN 5
`define UMCS_ACR_INDEX_EN 6
`define UMCS_CKS_RX_EXT 0
`define UMCS_CKS_TX_EXT 1
`define UMCS_CKS_TX_FROM_DTR 2
// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define UMCS_LCR_ENH_KEY 8'hBF
`define UMCS_RST_PRESCALE 8'h20
`define UMCS_RST_SAMPLE_CNT 8'h00
`define UMCS_SAMPLES_DEFAULT 5'h10
`define UMCS_SAMPLES_MIN 8'h04
`define UMCS_EIGHTHS_ONE 9'h008
`define UMCS_DEPTH_BYTE 8'h01
`define UMCS_DEPTH_STD 8'h10
`define UMCS_DEPTH_DEEP 8'h80
`endif

// >>> umcs_buffer.v
// Small valid/ready buffer that holds transmit words on their way to the transmitter.
`default_nettype none
module umcs_buffer #(
   parameter WIDTH = 8,
   parameter AW = 1
)(
   input wire clock_i,
   input wire rst_n_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   localparam DEPTH = 1 << AW;
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_ff;
   reg [AW-1:0] rd_ptr_ff;
   reg [AW:0] count_ff;
   wire push;
   wire pop;

   assign in_ready_o = (count_ff != DEPTH[AW:0]);
   assign out_valid_o = (count_ff != {(AW+1){1'b0}});
   assign out_data_o = mem_ff[rd_ptr_ff];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always @(posedge clock_i)
   begin
      if (push)
      begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end

   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         if (push & ~pop)
         begin
            count_ff <= count_ff + 1'b1;
         end
         else if (pop & ~push)
         begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> umcs_chk_sva.sv
// Concurrent checks on the ports of the mode and clock block.
`default_nettype none
module umcs_chk #(
   parameter DATA_W = 8
)(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic wr_stb_i,
   input wire logic rd_stb_i,
   input wire logic [7:0] rdata_o,
   input wire logic tx_valid_o,
   input wire logic tx_ready_i,
   input wire logic [DATA_W-1:0] tx_data_o,
   input wire logic [7:0] fifo_depth_o,
   input wire logic legacy_ext_en_o,
   input wire logic prog_trig_o,
   input wire logic [7:0] rx_trigger_o,
   input wire logic sample_tick_o,
   input wire logic tx_bit_tick_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Helper state
   // ----------------------------------------
   // The default-rate checks only hold until software first writes a register.
   logic fresh_ff;
   logic [7:0] gap_ff;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         fresh_ff <= 1'b1;
         gap_ff <= 8'h00;
      end
      else
      begin
         fresh_ff <= fresh_ff & ~wr_stb_i;
         gap_ff <= tx_bit_tick_o ? 8'h01 : ((gap_ff == 8'h00) ? 8'h00 : gap_ff + 8'h01);
      end
   end
   sequence quiet3_s;
      !sample_tick_o [*3];
   endsequence
   tick_period_a: assert property (sample_tick_o && fresh_ff |=> quiet3_s ##1 sample_tick_o)
      else $error("sample tick not every fourth clock after reset");
   bit_gap_a: assert property (tx_bit_tick_o && fresh_ff && gap_ff != 8'h00 |-> gap_ff == 8'h40)
      else $error("bit time not sixteen samples after reset");
   reset_depth_a: assert property ($rose(rst_n_i) |-> fifo_depth_o == 8'h01 && !legacy_ext_en_o)
      else $error("depth after reset not one");
   byte_mode_a: assert property (fifo_depth_o == 8'h01 |-> !legacy_ext_en_o && !prog_trig_o)
      else $error("mode feature active in byte mode");
   legacy_deep_a: assert property (legacy_ext_en_o |-> fifo_depth_o == 8'h80)
      else $error("size bit mode without deep buffers");
   prog_fifo_a: assert property (prog_trig_o |-> fifo_depth_o != 8'h01)
      else $error("programmable levels with buffers off");
   fixed_trig_a: assert property (!prog_trig_o |-> rx_trigger_o[7:2] == 6'h00)
      else $error("fixed receive level out of range");
   rdata_hold_a: assert property (!rd_stb_i |=> $stable(rdata_o))
      else $error("read data moved without a read");
   buf_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("stalled transmit word lost or changed");
endmodule
bind umcs_top umcs_chk #(.DATA_W(DATA_W)) umcs_chk_i (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .wr_stb_i(wr_stb_i), .rd_stb_i(rd_stb_i),
   .rdata_o(rdata_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
   .fifo_depth_o(fifo_depth_o), .legacy_ext_en_o(legacy_ext_en_o), .prog_trig_o(prog_trig_o),
   .rx_trigger_o(rx_trigger_o), .sample_tick_o(sample_tick_o), .tx_bit_tick_o(tx_bit_tick_o));
`default_nettype wire

// >>> umcs_sink.sv
// Far-side model: a transmitter taking words at its own pace and a modem giving pin clocks.
`default_nettype none
module umcs_sink (
   input wire logic clock_i,
   input wire logic stall_i,
   input wire logic pin_clk_en_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output var logic tx_ready_o,
   output var logic ring_o,
   output var logic term_o,
   output var logic dsr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   int cnt = 0;
   initial
   begin
      tx_ready_o = 1'b0;
      ring_o = 1'b0;
      term_o = 1'b0;
      dsr_o = 1'b0;
   end
   // Ready only every other cycle, so the buffer sees a slow taker as well.
   // Pins rest low while no clock is supplied, never at a stale phase.
   always @(negedge clock_i)
   begin
      cnt <= cnt + 1;
      tx_ready_o <= !stall_i && cnt[0];
      ring_o <= pin_clk_en_i && (cnt % 6 < 3);
      term_o <= pin_clk_en_i && (cnt % 10 < 5);
      dsr_o <= pin_clk_en_i && (cnt % 8 < 4);
   end
   always @(posedge clock_i)
      if (tx_valid_i && tx_ready_o)
         got.push_back(tx_data_i);
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench of the mode and clock block against a behavioural register model.
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0, rst_n_i = 1'b0, wr_stb_i = 1'b0, rd_stb_i = 1'b0;
   logic [2:0] addr_i = 3'h0;
   logic [7:0] wdata_i = 8'h00, rx_data_i = 8'h00, rx_fill = 8'h00, tx_fill = 8'h00, flow = 8'h00;
   logic [7:0] rdata, depth, rtrig, ttrig, flo, fhi, tx_data;
   logic stall = 1'b1, clk_en = 1'b0, tx_ready, wr_rdy, tx_valid, legacy, prog;
   logic stick, txt, rxt, ring, term, dsr;
   int failures = 0, samples_checked = 0;
   logic [31:0] seed = 32'd67936;
   logic [7:0] m_lcr = 8'h00, m_fcr = 8'h00, m_acr = 8'h00, m_idx = 8'h00;
   logic m_enh = 1'b0, m_efr4 = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] cprs[5] = '{8'h08, 8'h0D, 8'h0C, 8'h10, 8'h1B};
   logic [7:0] tcrs[5] = '{8'h00, 8'h03, 8'h04, 8'h0D, 8'h0F};
   umcs_top #(.DATA_W(8)) umcs_top_i (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_stb_i(wr_stb_i),
      .rd_stb_i(rd_stb_i), .wdata_i(wdata_i), .rdata_o(rdata), .rx_data_i(rx_data_i),
      .rx_fill_level_i(rx_fill), .tx_fill_level_i(tx_fill), .flow_status_i(flow),
      .tx_wr_ready_o(wr_rdy), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_data_o(tx_data),
      .ring_indicate_pin_i(ring), .terminal_ready_pin_i(term), .data_set_ready_pin_i(dsr),
      .fifo_depth_o(depth), .legacy_ext_en_o(legacy), .prog_trig_o(prog),
      .rx_trigger_o(rtrig), .tx_trigger_o(ttrig), .flow_low_o(flo), .flow_high_o(fhi),
      .sample_tick_o(stick), .tx_bit_tick_o(txt), .rx_bit_tick_o(rxt));
   umcs_sink umcs_sink_i (
      .clock_i(clock_i), .stall_i(stall), .pin_clk_en_i(clk_en), .tx_valid_i(tx_valid),
      .tx_data_i(tx_data), .tx_ready_o(tx_ready), .ring_o(ring), .term_o(term), .dsr_o(dsr));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chkn(input string what, input int e, input int g);
      samples_checked++;
      if (g != e)
      begin
         failures++;
         $display("mismatch %s expected %0d seen %0d", what, e, g);
      end
   endtask
   // The model follows each write at its taking edge; a refused word is never queued.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic rdy;
      @(negedge clock_i);
      rdy = wr_rdy;
      addr_i = a;
      wdata_i = d;
      wr_stb_i = 1'b1;
      @(negedge clock_i);
      wr_stb_i = 1'b0;
      if (a == 3'h0 && !m_lcr[7] && rdy === 1'b1)
         exp_q.push_back(d);
      if (a == 3'h2 && m_enh)
         m_efr4 = d[4];
      else if (a == 3'h2)
         m_fcr = m_lcr[7] ? d : {d[7:6], m_fcr[5], d[4:0]};
      if (a == 3'h3)
         m_enh = (d == 8'hBF);
      if (a == 3'h3)
         m_lcr = m_enh ? {1'b1, m_lcr[6:0]} : d;
      if (a == 3'h5 && !m_enh && m_idx == 8'h00)
         m_acr = d;
      if (a == 3'h7)
         m_idx = d;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(negedge clock_i);
      addr_i = a;
      rd_stb_i = 1'b1;
      @(negedge clock_i);
      rd_stb_i = 1'b0;
      @(negedge clock_i);
      v = rdata;
   endtask
   task automatic ird(input logic [7:0] idx, output logic [7:0] v);
      wr(3'h7, idx);
      rd(3'h5, v);
   endtask
   task automatic modes();
      logic [7:0] v;
      v = !m_fcr[0] ? 8'h01 : ((m_efr4 || m_fcr[5]) ? 8'h80 : 8'h10);
      chk("depth", v, depth);
      chk("legacy", {7'h0, m_fcr[0] & m_fcr[5] & !m_efr4}, {7'h0, legacy});
      chk("prog trig", {7'h0, m_fcr[0] & m_acr[5]}, {7'h0, prog});
      if (!(m_fcr[0] & m_acr[5]))
         chk("rx trig", {6'h0, m_fcr[7:6]}, rtrig);
      rd(3'h3, v);
      chk("line fmt", m_lcr, v);
   endtask
   // Counts the clocks of eight bit times, skipping two ticks that may carry the old setting.
   task automatic span(input logic rx, output int n);
      int k;
      n = 0;
      k = 0;
      for (int i = 0; i < 20000 && k < 10; i++)
      begin
         @(posedge clock_i);
         #1;
         if (k > 1)
            n++;
         if ((rx ? rxt : txt) === 1'b1)
            k++;
      end
      if (k < 10)
      begin
         failures++;
         conclude();
      end
   endtask
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial
   begin
      forever #20 clock_i = ~clock_i;
   end
   initial
   begin
      logic [7:0] v;
      logic [7:0] thr[4];
      logic [31:0] r;
      int n;
      repeat (10) @(negedge clock_i);
      rst_n_i = 1'b1;
      repeat (200) @(negedge clock_i);
      modes();
      rd(3'h4, v);
      chk("unmapped", 8'h00, v);
      rd(3'h5, v);
      chk("index closed", 8'h20, v);
      wr(3'h7, 8'h00);
      wr(3'h5, 8'h40);
      ird(8'h01, v);
      chk("prescale rst", 8'h20, v);
      ird(8'h03, v);
      chk("samples rst", 8'h00, v);
      wr(3'h2, 8'h21);
      modes();
      wr(3'h3, 8'h83);
      wr(3'h2, 8'h21);
      wr(3'h3, 8'h03);
      modes();
      $display("test reset and guard done");
      wr(3'h7, 8'h00);
      for (int i = 0; i < 60; i++)
      begin
         r = xs();
         case (r[1:0])
            2'd0: wr(3'h3, (r[3:2] == 2'd0) ? 8'hBF : r[11:4]);
            2'd1: wr(3'h2, r[15:8]);
            2'd2: wr(3'h5, (r[15:8] & 8'h20) | 8'h40);
            default: wr(3'h2, r[15:8] | 8'h01);
         endcase
         modes();
      end
      $display("test random modes done");
      wr(3'h3, 8'h03);
      wr(3'h2, 8'h01);
      wr(3'h5, 8'h60);
      for (int i = 0; i < 4; i++)
      begin
         r = xs();
         thr[i] = r[7:0];
         wr(3'h7, 8'h07 + i[7:0]);
         wr(3'h5, thr[i]);
      end
      modes();
      chk("rx level set", thr[0], rtrig);
      chk("tx level set", thr[1], ttrig);
      chk("flow low", thr[2], flo);
      chk("flow high", thr[3], fhi);
      r = xs();
      rx_fill = r[7:0];
      tx_fill = r[15:8];
      flow = r[23:16];
      ird(8'h05, v);
      chk("rx fill", rx_fill, v);
      ird(8'h06, v);
      chk("tx fill", tx_fill, v);
      ird(8'h04, v);
      chk("flow status", flow, v);
      $display("test indexed set done");
      for (int i = 0; i < 5; i++)
      begin
         wr(3'h7, 8'h01);
         wr(3'h5, cprs[i]);
         wr(3'h7, 8'h03);
         wr(3'h5, tcrs[i]);
         r = (tcrs[i] < 8'h04) ? 32'd16 : {24'h0, tcrs[i]};
         span(1'b0, n);
         chkn("tx bit span", int'(r) * int'(cprs[i]), n);
         span(1'b1, n);
         chkn("rx bit span", int'(r) * int'(cprs[i]), n);
      end
      $display("test prescaler done");
      wr(3'h7, 8'h02);
      wr(3'h5, 8'h03);
      clk_en = 1'b1;
      span(1'b0, n);
      chkn("ring clock span", 48, n);
      span(1'b1, n);
      chkn("dsr clock span", 64, n);
      wr(3'h5, 8'h07);
      span(1'b0, n);
      chkn("dtr clock span", 80, n);
      wr(3'h5, 8'h00);
      clk_en = 1'b0;
      $display("test external clock done");
      for (int i = 0; i < 11; i++)
      begin
         r = xs();
         stall = (i < 3);
         wr(3'h0, r[7:0]);
         if (i == 2)
            chk("full ready", 8'h00, {7'h0, wr_rdy});
      end
      for (int i = 0; i < 200 && umcs_sink_i.got.size() < exp_q.size(); i++)
         @(negedge clock_i);
      chkn("words", exp_q.size(), umcs_sink_i.got.size());
      while (exp_q.size() > 0 && umcs_sink_i.got.size() > 0)
         chk("word", exp_q.pop_front(), umcs_sink_i.got.pop_front());
      $display("test transmit buffer done");
      conclude();
   end
endmodule
`default_nettype wire
